// ==== hdl/lcd_column_driver.sv ====
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module lcd_column_driver (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic nibble_shift_clock,
    input wire logic line_latch_pulse,
    input wire logic chain_enable_pin_a_in,
    output logic chain_enable_pin_a_out,
    output logic chain_enable_pin_a_oe,
    input wire logic chain_enable_pin_b_in,
    output logic chain_enable_pin_b_out,
    output logic chain_enable_pin_b_oe,
    input wire logic shift_direction_select,
    input wire logic forced_blank_n,
    input wire logic ac_drive_phase,
    input wire logic frame_start_pulse,
    input wire logic [3:0] pixel_nibble,
    output lcd_pkg::lcd_level_t [lcd_pkg::LCD_COLS-1:0] segment_outputs,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // pin synchronisation and edges
    // ------------------------------------------------------------
    lcd_pkg::lcd_pins_t pins_raw;
    lcd_pkg::lcd_pins_t pins_s;
    logic [$bits(lcd_pkg::lcd_pins_t)-1:0] pins_s_vec;
    logic shift_prev_q;
    logic latch_prev_q;
    logic shift_fall;
    logic latch_rise;
    logic latch_fall;
    logic enable_in;
    logic enable_active;
    logic [3:0] nib_g;
    logic accept;

    assign pins_raw = '{
        shift_clk: nibble_shift_clock,
        latch: line_latch_pulse,
        ena_a: chain_enable_pin_a_in,
        ena_b: chain_enable_pin_b_in,
        dir: shift_direction_select,
        blank_n: forced_blank_n,
        ac: ac_drive_phase,
        frame: frame_start_pulse,
        nibble: pixel_nibble
    };

    lcd_sync #(
        .W($bits(lcd_pkg::lcd_pins_t))
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .d(pins_raw),
        .q(pins_s_vec)
    );

    assign pins_s = lcd_pkg::lcd_pins_t'(pins_s_vec);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            shift_prev_q <= 1'b0;
            latch_prev_q <= 1'b0;
        end else begin
            shift_prev_q <= pins_s.shift_clk;
            latch_prev_q <= pins_s.latch;
        end
    end

    assign shift_fall = shift_prev_q & ~pins_s.shift_clk;
    assign latch_rise = ~latch_prev_q & pins_s.latch;
    assign latch_fall = latch_prev_q & ~pins_s.latch;

    // direction low: pin a drives, pin b listens
    assign enable_in = pins_s.dir ? pins_s.ena_a : pins_s.ena_b;
    assign enable_active = ~enable_in;
    // power save: clock and data held low while disabled
    assign nib_g = enable_active ? pins_s.nibble : 4'h0;

    // ------------------------------------------------------------
    // nibble capture
    // ------------------------------------------------------------
    logic [lcd_pkg::LCD_COLS-1:0] data_q;
    logic [4:0] nib_cnt_q;
    logic seen_q;
    logic enout_q;

    assign accept = shift_fall && enable_active && !latch_rise
                    && (nib_cnt_q != lcd_pkg::LCD_NIBS_PER_LINE);

    function automatic logic [6:0] col_index(
        input logic [4:0] k,
        input logic [1:0] p,
        input logic dir
    );
        logic [6:0] lin;
        lin = {k, p};
        return dir ? lin : 7'(lcd_pkg::LCD_COL_LAST - lin);
    endfunction : col_index

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            data_q <= '0;
            nib_cnt_q <= 5'h00;
        end else if (latch_rise) begin
            nib_cnt_q <= 5'h00;
        end else if (accept) begin
            for (int p = 0; p < lcd_pkg::LCD_NIB_W; p++) begin
                data_q[col_index(nib_cnt_q, 2'(p), pins_s.dir)] <= nib_g[2'(3 - p)];
            end
            nib_cnt_q <= 5'(nib_cnt_q + 5'h01);
        end
    end

    // any accepted nibble since the last latch pulse
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            seen_q <= 1'b0;
        end else if (accept) begin
            seen_q <= 1'b1;
        end else if (latch_rise) begin
            seen_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // enable chain
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            enout_q <= 1'b1;
        end else if (latch_rise) begin
            enout_q <= 1'b1;
        end else if (accept && nib_cnt_q == lcd_pkg::LCD_NIB_LAST) begin
            enout_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            chain_enable_pin_a_out <= 1'b1;
            chain_enable_pin_a_oe <= 1'b0;
            chain_enable_pin_b_out <= 1'b1;
            chain_enable_pin_b_oe <= 1'b0;
        end else begin
            chain_enable_pin_a_out <= enout_q;
            chain_enable_pin_a_oe <= ~pins_s.dir;
            chain_enable_pin_b_out <= enout_q;
            chain_enable_pin_b_oe <= pins_s.dir;
        end
    end

    // ------------------------------------------------------------
    // display RAM, latch and row counter
    // ------------------------------------------------------------
    logic [lcd_pkg::LCD_COLS-1:0] ram_q [lcd_pkg::LCD_ROWS];
    logic [lcd_pkg::LCD_COLS-1:0] latch_q;
    logic [lcd_pkg::LCD_COLS-1:0] out_q;
    logic [7:0] row_q;
    logic [7:0] line_cnt_q;
    logic [7:0] lines_q;
    lcd_pkg::lcd_mode_t mode_q;
    logic wr;

    // write only when the line carried data; blanking has no say
    assign wr = latch_rise && seen_q;

    always_ff @(posedge ref_clk) begin
        if (wr) begin
            ram_q[row_q] <= data_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mode_q <= lcd_pkg::LCD_MODE_TRANSFER;
        end else if (latch_rise) begin
            mode_q <= seen_q ? lcd_pkg::LCD_MODE_TRANSFER : lcd_pkg::LCD_MODE_REFRESH;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            latch_q <= '0;
        end else if (latch_rise) begin
            latch_q <= ram_q[row_q];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            out_q <= '0;
        end else if (latch_fall) begin
            out_q <= latch_q;
        end
    end

    // row advances after the write, in both modes
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            row_q <= lcd_pkg::LCD_ROW_FIRST;
        end else if (latch_fall) begin
            if (pins_s.frame) begin
                row_q <= lcd_pkg::LCD_ROW_FIRST;
            end else if (row_q == lcd_pkg::LCD_ROW_LAST) begin
                row_q <= lcd_pkg::LCD_ROW_FIRST;
            end else begin
                row_q <= 8'(row_q + 8'h01);
            end
        end
    end

    // latch pulses counted per frame
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            line_cnt_q <= 8'h00;
            lines_q <= 8'h00;
        end else if (latch_fall) begin
            if (pins_s.frame) begin
                lines_q <= line_cnt_q;
                line_cnt_q <= 8'h01;
            end else if (line_cnt_q != 8'hFF) begin
                line_cnt_q <= 8'(line_cnt_q + 8'h01);
            end
        end
    end

    // ------------------------------------------------------------
    // segment levels
    // ------------------------------------------------------------
    logic ctrl_blank_q;
    logic blank;
    lcd_pkg::lcd_level_t [lcd_pkg::LCD_COLS-1:0] seg_d;

    assign blank = ~pins_s.blank_n | ctrl_blank_q;

    for (genvar i = 0; i < lcd_pkg::LCD_COLS; i++) begin : g_col
        assign seg_d[i] = blank ? lcd_pkg::LCD_LEVEL_TOP :
                          out_q[i] ? (pins_s.ac ? lcd_pkg::LCD_LEVEL_TOP
                                                : lcd_pkg::LCD_LEVEL_BOTTOM) :
                          (pins_s.ac ? lcd_pkg::LCD_LEVEL_UPPER_MID
                                     : lcd_pkg::LCD_LEVEL_LOWER_MID);
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            segment_outputs <= '{default: lcd_pkg::LCD_LEVEL_TOP};
        end else begin
            segment_outputs <= seg_d;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] rd_word;
    logic rd_ok;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_have_q && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr[7:0];
            end else if (aw_have_q && w_have_q) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_have_q && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (aw_have_q && w_have_q) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl_blank_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= lcd_pkg::LCD_RESP_OKAY;
        end else if (aw_have_q && w_have_q) begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_q[7:2] == lcd_pkg::LCD_REG_CTRL[7:2]) begin
                s_axi_bresp <= lcd_pkg::LCD_RESP_OKAY;
                if (wstrb_q[0]) begin
                    ctrl_blank_q <= wdata_q[lcd_pkg::LCD_CTRL_BLANK_BIT];
                end
            end else if (awaddr_q[7:2] == lcd_pkg::LCD_REG_STATUS[7:2]
                         || awaddr_q[7:2] == lcd_pkg::LCD_REG_LINES[7:2]) begin
                s_axi_bresp <= lcd_pkg::LCD_RESP_OKAY;
            end else begin
                s_axi_bresp <= lcd_pkg::LCD_RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr[7:2] == lcd_pkg::LCD_REG_CTRL[7:2]) begin
            rd_word[lcd_pkg::LCD_CTRL_BLANK_BIT] = ctrl_blank_q;
        end else if (s_axi_araddr[7:2] == lcd_pkg::LCD_REG_STATUS[7:2]) begin
            rd_word[lcd_pkg::LCD_ST_ROW_LSB +: 8] = row_q;
            rd_word[lcd_pkg::LCD_ST_NIB_LSB +: 5] = nib_cnt_q;
            rd_word[lcd_pkg::LCD_ST_REFRESH_BIT] = (mode_q == lcd_pkg::LCD_MODE_REFRESH);
            rd_word[lcd_pkg::LCD_ST_ENOUT_BIT] = enout_q;
        end else if (s_axi_araddr[7:2] == lcd_pkg::LCD_REG_LINES[7:2]) begin
            rd_word[7:0] = lines_q;
        end else begin
            rd_ok = 1'b0;
        end
        if (|s_axi_araddr[31:8]) begin
            rd_ok = 1'b0;
            rd_word = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= lcd_pkg::LCD_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? lcd_pkg::LCD_RESP_OKAY : lcd_pkg::LCD_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : lcd_column_driver

// ==== hdl/lcd_pkg.sv ====
// Function
// - capture nibble on shift clock fall when enabled
// - latch rise loads selected RAM row
// - latch pulse writes line into RAM row
// - latch pulse restarts the nibble acceptance count
// - segment data changes at latch fall
// - latch pulse drives chain enable output high
// - chain enable output low after 80 bits
// - direction select swaps chain pin roles
// - direction select mirrors nibble to column mapping
// - blank input low forces all outputs top
// - blanking leaves RAM contents untouched
// - frame start high resets row counter
// - rows scanned equal latch pulses per frame
// - frames of 64 to 200 rows supported
// - RAM holds 200 rows of 80 bits
// - 80 segment outputs from latched row
// - 4-bit shared bus taken in turn
// - no shift clocks means self-refresh, no write
// - enable input high gates clock and data low
// - level from data and AC phase
package lcd_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned LCD_COLS = 80;
    localparam int unsigned LCD_ROWS = 200;
    localparam int unsigned LCD_NIB_W = 4;
    localparam logic [6:0] LCD_COL_LAST = 7'h4F;
    localparam logic [7:0] LCD_ROW_LAST = 8'hC7;
    localparam logic [7:0] LCD_ROW_FIRST = 8'h00;
    localparam logic [4:0] LCD_NIBS_PER_LINE = 5'h14;
    localparam logic [4:0] LCD_NIB_LAST = 5'h13;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] LCD_REG_CTRL = 8'h00;
    localparam logic [7:0] LCD_REG_STATUS = 8'h04;
    localparam logic [7:0] LCD_REG_LINES = 8'h08;
    localparam int unsigned LCD_CTRL_BLANK_BIT = 0;
    localparam int unsigned LCD_ST_ROW_LSB = 0;
    localparam int unsigned LCD_ST_NIB_LSB = 8;
    localparam int unsigned LCD_ST_REFRESH_BIT = 16;
    localparam int unsigned LCD_ST_ENOUT_BIT = 17;
    localparam logic [1:0] LCD_RESP_OKAY = 2'h0;
    localparam logic [1:0] LCD_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LCD_LEVEL_TOP = 2'b00,
        LCD_LEVEL_UPPER_MID = 2'b01,
        LCD_LEVEL_LOWER_MID = 2'b10,
        LCD_LEVEL_BOTTOM = 2'b11
    } lcd_level_t;

    typedef enum logic {
        LCD_MODE_TRANSFER = 1'b0,
        LCD_MODE_REFRESH = 1'b1
    } lcd_mode_t;

    typedef struct packed {
        logic shift_clk;
        logic latch;
        logic ena_a;
        logic ena_b;
        logic dir;
        logic blank_n;
        logic ac;
        logic frame;
        logic [3:0] nibble;
    } lcd_pins_t;

endpackage : lcd_pkg

// ==== hdl/lcd_sync.sv ====
`timescale 1ns/1ps
module lcd_sync #(
    parameter int unsigned W = 1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : lcd_sync

// ==== verif/lcd_column_driver_asserts.sv ====
`timescale 1ns/1ps
module lcd_column_driver_asserts (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic nibble_shift_clock,
    input wire logic line_latch_pulse,
    input wire logic chain_enable_pin_a_in,
    input wire logic chain_enable_pin_a_out,
    input wire logic chain_enable_pin_a_oe,
    input wire logic chain_enable_pin_b_in,
    input wire logic chain_enable_pin_b_out,
    input wire logic chain_enable_pin_b_oe,
    input wire logic shift_direction_select,
    input wire logic forced_blank_n,
    input wire logic ac_drive_phase,
    input wire lcd_pkg::lcd_level_t [lcd_pkg::LCD_COLS-1:0] segment_outputs,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    logic [159:0] seg_v;
    logic drv;
    logic lsn;
    logic sclk_q;
    logic lat_q;
    logic [4:0] cnt_q;
    assign seg_v = segment_outputs;
    assign drv = chain_enable_pin_a_oe ? chain_enable_pin_a_out : chain_enable_pin_b_out;
    assign lsn = chain_enable_pin_a_oe ? chain_enable_pin_b_in : chain_enable_pin_a_in;
    always_ff @(posedge ref_clk) begin
        sclk_q <= nibble_shift_clock;
        lat_q <= line_latch_pulse;
    end
    // enabled shift pin falls since the last latch rise
    always_ff @(posedge ref_clk) begin
        if (!reset_n || (line_latch_pulse && !lat_q)) begin
            cnt_q <= 5'h00;
        end else if (sclk_q && !nibble_shift_clock && !lsn && cnt_q != 5'h14) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_latch_rise;
        $rose(line_latch_pulse);
    endsequence
    sequence s_quiet;
        ($stable(ac_drive_phase) && $stable(forced_blank_n) && $stable(line_latch_pulse)
            && !s_axi_wvalid) [*6];
    endsequence
    a_oe_roles: assert property ($stable(shift_direction_select) [*6]
        |-> chain_enable_pin_a_oe == !shift_direction_select
            && chain_enable_pin_b_oe == shift_direction_select)
        else $error("chain pin roles wrong");
    a_blank_top: assert property ((!forced_blank_n) [*6] |-> seg_v == 160'h0)
        else $error("blank not at top level");
    a_seg_hold: assert property (s_quiet |=> $stable(seg_v))
        else $error("segments moved without cause");
    a_ac_level: assert property (ac_drive_phase [*6]
        |-> (seg_v & {80{2'h2}}) == 160'h0)
        else $error("level wrong for ac high");
    a_chain_rise: assert property (s_latch_rise |-> ##[1:6] drv)
        else $error("chain out not high after latch");
    a_chain_low: assert property ($fell(drv) |-> cnt_q == 5'h14)
        else $error("chain out fell at wrong count");
    a_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule : lcd_column_driver_asserts
bind lcd_column_driver lcd_column_driver_asserts chk_i (.*);

// ==== verif/lcd_column_driver_tb.sv ====
`timescale 1ns/1ps
module lcd_column_driver_tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic nibble_shift_clock, line_latch_pulse, frame_start_pulse;
    logic [3:0] pixel_nibble;
    logic shift_direction_select = 1'b0;
    logic forced_blank_n = 1'b0;
    logic ac_drive_phase = 1'b1;
    logic far_en_n = 1'b0;
    logic chain_enable_pin_a_out, chain_enable_pin_a_oe;
    logic chain_enable_pin_b_out, chain_enable_pin_b_oe;
    lcd_pkg::lcd_level_t [79:0] segment_outputs;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic chain_enable_pin_a_in = chain_enable_pin_a_oe ? chain_enable_pin_a_out : far_en_n;
    wire logic chain_enable_pin_b_in = chain_enable_pin_b_oe ? chain_enable_pin_b_out : far_en_n;
    wire logic drv = shift_direction_select ? chain_enable_pin_b_out : chain_enable_pin_a_out;
    logic [79:0] ram_m [int];
    int fails = 0;
    int compares = 0;
    int seed = 50;
    lcd_column_driver dut (.*);
    lcd_ctl_model ctl (
        .ref_clk(ref_clk),
        .sclk(nibble_shift_clock),
        .latch(line_latch_pulse),
        .frame(frame_start_pulse),
        .nib(pixel_nibble)
    );
    always #2.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        bit aw_done;
        bit w_done;
        bit b_done;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done && b_done)) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
            if (s_axi_bready && s_axi_bvalid) begin
                chk(160'(s_axi_bresp), 160'(r));
                s_axi_bready <= 1'b0;
                b_done = 1'b1;
            end
        end
    endtask : wr
    // ready raised late so the held answer is seen
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        bit ar_done;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!ar_done) begin
            @(posedge ref_clk);
            if (s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                ar_done = 1'b1;
            end
        end
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge ref_clk);
        chk(160'({s_axi_rresp, s_axi_rdata}), 160'({r, e}));
        s_axi_rready <= 1'b0;
    endtask : rd
    function automatic logic [159:0] expv(input logic [79:0] b);
        logic [159:0] v;
        for (int i = 0; i < 80; i++) begin
            v[2*i +: 2] = {~ac_drive_phase,
                ac_drive_phase ^ (shift_direction_select ? b[79-i] : b[i])};
        end
        return v;
    endfunction : expv
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        logic [79:0] d;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(32'h4, 32'h20000, 2'h0);
        rd(32'h8, 32'h0, 2'h0);
        rd(32'hC, 32'h0, 2'h2);
        wr(32'h10, 32'h1, 2'h2);
        rd(32'h0, 32'h0, 2'h0);
        for (int s = 0; s < 2; s++) begin
            shift_direction_select <= s[0];
            ac_drive_phase <= 1'($random(seed));
            d = {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
            repeat (8) @(posedge ref_clk);
            chk(160'({chain_enable_pin_a_oe, chain_enable_pin_b_oe}), 160'({~s[0], s[0]}));
            ctl.strobe(1'b1);
            ctl.send(d, 21);
            rd(32'h4, 32'h11400, 2'h0);
            chk(160'(drv), 160'h0);
            ctl.strobe(1'b0);
            ram_m[0] = d;
            chk(160'(drv), 160'h1);
            ctl.strobe(1'b1);
            rd(32'h4, 32'h30000, 2'h0);
            rd(32'h8, 32'h2, 2'h0);
            ctl.send(~d, 20);
            ctl.strobe(1'b0);
            chk(segment_outputs, 160'h0);
            forced_blank_n <= 1'b1;
            repeat (8) @(posedge ref_clk);
            chk(segment_outputs, expv(ram_m[0]));
            ac_drive_phase <= ~ac_drive_phase;
            repeat (8) @(posedge ref_clk);
            chk(segment_outputs, expv(ram_m[0]));
            wr(32'h0, 32'h1, 2'h0);
            rd(32'h0, 32'h1, 2'h0);
            chk(segment_outputs, 160'h0);
            wr(32'h0, 32'h0, 2'h0);
            rd(32'h0, 32'h0, 2'h0);
            chk(segment_outputs, expv(ram_m[0]));
            forced_blank_n <= 1'b0;
            far_en_n <= 1'b1;
            ctl.send(d, 4);
            rd(32'h4, 32'h20001, 2'h0);
            far_en_n <= 1'b0;
        end
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        end_sim();
    end
endmodule : lcd_column_driver_tb

// ==== verif/lcd_ctl_model.sv ====
`timescale 1ns/1ps
module lcd_ctl_model (
    input wire logic ref_clk,
    output logic sclk,
    output logic latch,
    output logic frame,
    output logic [3:0] nib
);
    initial begin
        sclk = 1'b0;
        latch = 1'b0;
        frame = 1'b0;
        nib = 4'hA;
    end
    // one nibble per 32 cycles, first pixel on bit 3
    task automatic send(input logic [79:0] b, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge ref_clk);
            sclk <= 1'b1;
            nib <= b[79 - 4 * (k % 20) -: 4];
            repeat (16) @(posedge ref_clk);
            sclk <= 1'b0;
            repeat (15) @(posedge ref_clk);
        end
    endtask : send
    // latch pulse, frame start held past its fall
    task automatic strobe(input logic frm);
        @(posedge ref_clk);
        nib <= ~nib;
        frame <= frm;
        latch <= 1'b1;
        repeat (8) @(posedge ref_clk);
        latch <= 1'b0;
        repeat (8) @(posedge ref_clk);
        frame <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask : strobe
endmodule : lcd_ctl_model
